// File: src/lsb_top.sv
/*
  Segment and backplane scan driver with an AHB-Lite register slave.
  Holds the display memory, the control and status registers, and the
  per-pin drive level selection for static, one-half and one-third bias.
  Assumes a single AHB-Lite master on ref_clk (40 MHz) and an analogue
  stage outside that turns each two-bit level code into a rail.
*/
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
module lsb_top #(
  parameter int SEG_COUNT = 40  // 40 on the larger package, 36 on the smaller
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // panel drive level codes
  output logic [2*SEG_COUNT-1:0] frontplane_drive_outputs,
  output logic [1:0] backplane_drive_0,
  output logic [1:0] backplane_drive_1,
  output logic [1:0] backplane_drive_2,
  output logic [1:0] backplane_drive_3,
  output logic panel_drive_active
);

  // ************************************************************
  // bus address phase
  // ************************************************************

  // a transfer is taken when selected, nonseq or seq, and the bus is ready
  wire bus_take = hsel && hready && htrans[1];
  wire take_wr = bus_take && hwrite;
  wire take_rd = bus_take && !hwrite;
  wire [5:0] addr_idx = haddr[7:2];  // memory index from byte address
  wire addr_in_mem = (haddr[31:8] == lsb_pkg::MEM_BASE[31:8]) &&
                     (32'(addr_idx) < SEG_COUNT);
  wire addr_ctrl = (haddr == lsb_pkg::CTRL_ADDR);
  wire addr_stat = (haddr == lsb_pkg::STAT_ADDR);

  logic wr_pend_r;          // write data phase pending
  logic wr_mem_r;           // pending write targets memory
  logic wr_ctrl_r;          // pending write targets control
  logic [5:0] wr_idx_r;     // pending memory index

  // capture write address phase; writes to unmapped space vanish
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_mem_r <= 1'b0;
      wr_ctrl_r <= 1'b0;
      wr_idx_r <= 6'h00;
    end else begin
      wr_pend_r <= take_wr;
      wr_mem_r <= take_wr && addr_in_mem;
      wr_ctrl_r <= take_wr && addr_ctrl;
      wr_idx_r <= addr_idx;
    end
  end

  // ************************************************************
  // control register
  // ************************************************************

  logic [31:0] ctrl_r;  // mode, enables, divider
  wire [31:0] ctrl_nxt = (hwdata & lsb_pkg::CTRL_WMASK);

  // written in the data phase; no side effects beyond storage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= lsb_pkg::CTRL_RESET;
    end else if (wr_ctrl_r) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // decoded fields
  wire [1:0] slot_m1 = ctrl_r[lsb_pkg::CTRL_SLOTS_LSB +: 2];
  wire bias_third = ctrl_r[lsb_pkg::CTRL_BIAS_BIT];
  wire oe_on = ctrl_r[lsb_pkg::CTRL_OE_BIT];
  wire disp_on = ctrl_r[lsb_pkg::CTRL_ON_BIT];
  wire [15:0] div_val = ctrl_r[lsb_pkg::CTRL_DIV_LSB +: 16];
  wire is_static = (slot_m1 == 2'h0);
  // display on without output enable stays dark: both bits must be set by the same write, which replaces the whole register
  wire mem_drive = oe_on && disp_on;

  // ************************************************************
  // scan timer and display memory
  // ************************************************************

  lsb_scan_if scan ();

  assign scan.run = oe_on;
  assign scan.div = div_val;
  assign scan.slot_m1 = slot_m1;

  lsb_scan_timer u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .scan(scan)
  );

  wire [3:0] mem_rd_data;
  wire [SEG_COUNT-1:0] slot_bits;

  // only the low nibble of written data is stored
  lsb_disp_mem #(
    .SEG_COUNT(SEG_COUNT)
  ) u_mem (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(wr_mem_r),
    .wr_idx(wr_idx_r),
    .wr_data(hwdata[3:0]),
    .rd_idx(addr_idx),
    .rd_data(mem_rd_data),
    .slot(scan.slot),
    .slot_bits(slot_bits)
  );

  // ************************************************************
  // bus read data and response
  // ************************************************************

  wire [31:0] stat_val = {28'h0000000, oe_on, scan.phase, scan.slot};
  wire [31:0] mem_word = {28'h0000000, mem_rd_data};
  wire [31:0] rd_sel = addr_in_mem ? mem_word :
                       addr_ctrl ? ctrl_r :
                       addr_stat ? stat_val : 32'h0000_0000;

  // read data sampled at the address phase, so it stands in the data phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= take_rd ? rd_sel : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ************************************************************
  // drive level selection
  // ************************************************************

  // phase 0: select backplane on top, selected segment on ground;
  // phase 1 swaps them, which cancels DC over two frames
  wire ph = scan.phase;
  wire [1:0] com_sel = ph ? lsb_pkg::LVL_GND : lsb_pkg::LVL_TOP;
  wire [1:0] seg_sel = ph ? lsb_pkg::LVL_TOP : lsb_pkg::LVL_GND;
  // third bias deselect uses the middle rails, half bias and static follow the backplane
  wire [1:0] seg_desel = bias_third && !is_static ?
                         (ph ? lsb_pkg::LVL_LOW : lsb_pkg::LVL_UP) :
                         (ph ? lsb_pkg::LVL_GND : lsb_pkg::LVL_TOP);
  wire [1:0] com_desel = bias_third ?
                         (ph ? lsb_pkg::LVL_UP : lsb_pkg::LVL_LOW) :
                         lsb_pkg::LVL_UP;

  logic [1:0] com_nxt [4];
  logic [2*SEG_COUNT-1:0] seg_nxt;

  // backplanes: static drives all four alike, else one select at a time
  genvar ci;
  generate
    for (ci = 0; ci < 4; ci++) begin : g_com
      wire com_used = (2'(ci) <= slot_m1);
      wire com_active = is_static || (scan.slot == 2'(ci));
      assign com_nxt[ci] = !oe_on ? lsb_pkg::LVL_GND :
                           !com_used && !is_static ? lsb_pkg::LVL_GND :
                           (mem_drive && com_active) ? com_sel :
                           (is_static ? com_sel : com_desel);
    end
  endgenerate

  // segments: memory bit of the current slot picks select or deselect
  genvar si;
  generate
    for (si = 0; si < SEG_COUNT; si++) begin : g_seg
      wire bit_on = mem_drive && slot_bits[si];
      assign seg_nxt[2*si +: 2] = !oe_on ? lsb_pkg::LVL_GND :
                                  bit_on ? seg_sel : seg_desel;
    end
  endgenerate

  // ************************************************************
  // output flops
  // ************************************************************

  // every pin is registered so level codes never glitch between rails
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frontplane_drive_outputs <= '0;
      backplane_drive_0 <= lsb_pkg::LVL_GND;
      backplane_drive_1 <= lsb_pkg::LVL_GND;
      backplane_drive_2 <= lsb_pkg::LVL_GND;
      backplane_drive_3 <= lsb_pkg::LVL_GND;
      panel_drive_active <= 1'b0;
    end else begin
      frontplane_drive_outputs <= seg_nxt;
      backplane_drive_0 <= com_nxt[0];
      backplane_drive_1 <= com_nxt[1];
      backplane_drive_2 <= com_nxt[2];
      backplane_drive_3 <= com_nxt[3];
      panel_drive_active <= oe_on;
    end
  end

endmodule

// File: src/lsb_pkg.sv
/*
  Constants shared by the segment/backplane scan design: register map,
  field positions, reset values and drive level codes.
  Assumes a 32-bit AHB-Lite register bus, one register per aligned word.
*/
package lsb_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [31:0] MEM_BASE = 32'h0000_0000;   // byte i of display memory at 4*i
  localparam logic [5:0] MEM_FIRST_IDX = 6'h00;       // first display memory index
  localparam logic [5:0] MEM_LAST_IDX_LARGE = 6'h27;  // last index, larger package
  localparam logic [5:0] MEM_LAST_IDX_SMALL = 6'h23;  // last index, smaller package
  localparam logic [31:0] CTRL_ADDR = 32'h0000_0100;  // mode and enable control
  localparam logic [31:0] STAT_ADDR = 32'h0000_0104;  // scan state, read only

  // ************************************************************
  // control register fields
  // ************************************************************
  localparam int CTRL_SLOTS_LSB = 0;    // two bits: active slot count minus one
  localparam int CTRL_BIAS_BIT = 2;     // 0: one-half bias, 1: one-third bias
  localparam int CTRL_OE_BIT = 6;       // output enable, deselect drive
  localparam int CTRL_ON_BIT = 7;       // display on, memory driven output
  localparam int CTRL_DIV_LSB = 16;     // sixteen bits: display clock divider
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'hffff_00c7;  // writable bits

  // ************************************************************
  // status register fields
  // ************************************************************
  localparam int STAT_SLOT_LSB = 0;     // two bits: current slot
  localparam int STAT_PHASE_BIT = 2;    // current frame polarity
  localparam int STAT_RUN_BIT = 3;      // scan running

  // ************************************************************
  // drive level codes, one two-bit code per pin
  // ************************************************************
  localparam logic [1:0] LVL_GND = 2'h0;  // drive ground rail
  localparam logic [1:0] LVL_LOW = 2'h1;  // lower middle rail
  localparam logic [1:0] LVL_UP = 2'h2;   // upper middle rail, merged rails in half bias
  localparam logic [1:0] LVL_TOP = 2'h3;  // top drive rail

  // ************************************************************
  // reset values of scan state and display memory
  // ************************************************************
  localparam logic [1:0] SLOT_RESET = 2'h0;
  localparam logic [15:0] DIV_COUNT_RESET = 16'h0000;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;

endpackage

// File: src/lsb_scan_if.sv
/*
  Carrier between the top module and the scan timer: configuration out,
  slot index and frame polarity back.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface lsb_scan_if;
  logic run;          // scan enabled
  logic [15:0] div;   // slot length minus one, in ref_clk cycles
  logic [1:0] slot_m1;  // active slot count minus one
  logic [1:0] slot;   // current slot index
  logic phase;        // frame polarity

  modport timer (input run, input div, input slot_m1, output slot, output phase);
  modport ctrl (output run, output div, output slot_m1, input slot, input phase);
endinterface

// File: src/lsb_scan_timer.sv
/*
  Scan timer: divides ref_clk into the display clock, steps the slot
  index once per display clock and flips polarity at each frame end.
  Assumes configuration comes from logic on the same clock.
*/
`timescale 1ns/10ps
module lsb_scan_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // scan carrier
  lsb_scan_if.timer scan
);

  logic [15:0] div_cnt_r;  // cycles left in this slot
  logic [15:0] div_cnt_nxt;
  logic [1:0] slot_r;      // current slot
  logic [1:0] slot_nxt;
  logic phase_r;           // frame polarity
  logic phase_nxt;
  wire slot_end = (div_cnt_r == 16'h0000);  // display clock edge
  wire frame_end = slot_end && (slot_r >= scan.slot_m1);  // last slot done

  // next state; a stopped scan parks at slot 0 so restart is clean
  always_comb begin
    div_cnt_nxt = div_cnt_r;
    slot_nxt = slot_r;
    phase_nxt = phase_r;
    if (!scan.run) begin
      div_cnt_nxt = scan.div;
      slot_nxt = lsb_pkg::SLOT_RESET;
    end else if (slot_end) begin
      div_cnt_nxt = scan.div;
      if (frame_end) begin
        slot_nxt = lsb_pkg::SLOT_RESET;
        phase_nxt = ~phase_r;
      end else begin
        slot_nxt = slot_r + 2'h1;
      end
    end else begin
      div_cnt_nxt = div_cnt_r - 16'h0001;
    end
  end

  // state flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= lsb_pkg::DIV_COUNT_RESET;
      slot_r <= lsb_pkg::SLOT_RESET;
      phase_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      slot_r <= slot_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign scan.slot = slot_r;
  assign scan.phase = phase_r;

endmodule

// File: src/lsb_disp_mem.sv
/*
  Display memory: one nibble per segment output, written from the bus,
  read back by index, and sliced by the current slot for the scan.
  Assumes writes and reads come from logic on the same clock.
*/
`timescale 1ns/10ps
module lsb_disp_mem #(
  parameter int SEG_COUNT = 40
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // bus write port
  input wire logic wr_en,
  input wire logic [5:0] wr_idx,
  input wire logic [3:0] wr_data,
  // bus read port
  input wire logic [5:0] rd_idx,
  output logic [3:0] rd_data,
  // scan port
  input wire logic [1:0] slot,
  output logic [SEG_COUNT-1:0] slot_bits
);

  logic [3:0] mem_r [SEG_COUNT];  // only the low nibble exists; upper bits read zero

  // one write port; every stored bit keeps its value, used or not
  genvar gi;
  generate
    for (gi = 0; gi < SEG_COUNT; gi++) begin : g_ent
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_r[gi] <= lsb_pkg::NIBBLE_RESET;
        end else if (wr_en && (wr_idx == 6'(gi))) begin
          mem_r[gi] <= wr_data;
        end
      end
      assign slot_bits[gi] = mem_r[gi][slot];
    end
  endgenerate

  // readback, zero past the last entry
  assign rd_data = (32'(rd_idx) < SEG_COUNT) ? mem_r[rd_idx] : 4'h0;

endmodule

// File: tb/lsb_panel_model.sv
/*
  Passive glass panel: flags every pixel that sees the full on-voltage.
  Assumes the driver's two-bit level codes; unused backplanes are open.
*/
`timescale 1ns/10ps
module lsb_panel_model #(
  parameter int SEG_COUNT = 40
) (
  // level codes from the driver
  input wire logic [2*SEG_COUNT-1:0] fp,
  input wire logic [7:0] bp,
  // lit pixels, row k at [k*SEG_COUNT +: SEG_COUNT]
  output logic [4*SEG_COUNT-1:0] lit
);
  // ************************************************************
  // pixel voltage
  // ************************************************************
  // full swing only between top rail and ground; middle pairs stay dark
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < SEG_COUNT; i++) begin
        lit[k*SEG_COUNT+i] = (bp[2*k +: 2] ^ fp[2*i +: 2]) == 2'h3 && bp[2*k] == bp[2*k+1];
      end
    end
  end
endmodule

// File: tb/lsb_monitor.sv
/*
  Checker for the scan driver pins and its register bus.
  Assumes it is bound to lsb_top and sees only its ports.
*/
`timescale 1ns/10ps
module lsb_monitor #(
  parameter int SEG_COUNT = 40
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // panel codes
  input wire logic [2*SEG_COUNT-1:0] frontplane_drive_outputs,
  input wire logic [1:0] backplane_drive_0,
  input wire logic [1:0] backplane_drive_1,
  input wire logic [1:0] backplane_drive_2,
  input wire logic [1:0] backplane_drive_3,
  input wire logic panel_drive_active
);
  // ************************************************************
  // control shadow and run timer
  // ************************************************************
  logic aw_q; // control write now in data phase
  logic [31:0] ctl_q; // last control value
  logic [1:0] age_q; // cycles since that write, held at 3
  logic [7:0] trk_q; // backplane codes one cycle back
  logic [15:0] run_q; // cycles the codes stood still
  logic seen_q; // a clean boundary passed since settling
  wire [7:0] trk = {backplane_drive_3, backplane_drive_2, backplane_drive_1, backplane_drive_0};
  wire [1:0] seg0 = frontplane_drive_outputs[1:0];
  wire moved = trk != trk_q;
  wire calm = age_q == 2'h3 && ctl_q[6]; // pins follow the new value by now
  wire multi = ctl_q[1:0] != 2'h0;
  wire rd_go = hsel && hready && htrans[1] && !hwrite;
  // active backplanes at a rail level, i.e. selected
  wire [3:0] selv = {ctl_q[1:0] == 2'h3 && trk[7] == trk[6], ctl_q[1:0] >= 2'h2 && trk[5] == trk[4],
    ctl_q[1:0] >= 2'h1 && trk[3] == trk[2], trk[1] == trk[0]};

  // shadow is only trusted once age saturates, the pins lag the write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_q <= 1'b0;
      ctl_q <= 32'h0;
      age_q <= 2'h0;
      trk_q <= 8'h0;
      run_q <= 16'h0;
      seen_q <= 1'b0;
    end else begin
      aw_q <= hsel && hready && htrans[1] && hwrite && haddr == lsb_pkg::CTRL_ADDR;
      ctl_q <= aw_q ? (hwdata & lsb_pkg::CTRL_WMASK) : ctl_q;
      age_q <= aw_q ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
      trk_q <= trk;
      run_q <= moved ? 16'h0 : run_q + 16'h1;
      seen_q <= calm && (seen_q || moved);
    end
  end

  // ************************************************************
  // properties
  // ************************************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_upper_zero: assert property (rd_go && haddr < 32'h100 |=> hrdata[31:4] == 28'h0)
    else $error("memory read shows upper bits");
  a_unmapped_zero: assert property (rd_go && haddr >= 32'h200 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_quiet_off: assert property (!panel_drive_active && !$past(panel_drive_active)
    |-> trk == 8'h0 && frontplane_drive_outputs == '0) else $error("pins driven while off");
  a_static_twins: assert property (calm && !multi |-> trk == {4{backplane_drive_0}})
    else $error("static backplanes differ");
  a_one_select: assert property (calm && ctl_q[7] && multi |-> $onehot(selv))
    else $error("not exactly one backplane selected");
  a_half_mid: assert property (calm && multi && !ctl_q[2] |-> trk[1:0] != lsb_pkg::LVL_LOW)
    else $error("half bias backplane on lower middle rail");
  a_third_swap: assert property (calm && multi && ctl_q[2] && (^seg0) && (^trk[1:0])
    |-> seg0 != trk[1:0]) else $error("third bias middle rails not swapped");
  a_sel_pair: assert property (calm && ctl_q[7] && multi && ctl_q[2] && selv[0]
    |-> seg0 != trk[1:0]) else $error("segment equals selected backplane");
  a_slot_len: assert property (calm && ctl_q[7] && seen_q && moved
    |-> run_q == ctl_q[31:16]) else $error("slot length wrong");

  c_static_on: cover property (calm && ctl_q[7] && !multi);
  c_four_third: cover property (calm && ctl_q[7] && ctl_q[2:0] == 3'h7);
  c_unmapped_rd: cover property (rd_go && haddr >= 32'h200);
endmodule

// File: tb/lsb_top_bench.sv
/*
  Self-checking bench for lsb_top with a panel model on its pins.
  Assumes a zero-wait slave; bus timing follows hreadyout anyway.
*/
`timescale 1ns/10ps
module lsb_top_bench;
  // ************************************************************
  // signals
  // ************************************************************
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire hreadyout; // ready of dut only, also taken as the bus hready for both builds
  wire [31:0] hrdata;
  wire [31:0] hrdata_s; // same bus, smaller package build
  wire hresp;
  wire [79:0] fp;
  wire [1:0] bp0, bp1, bp2, bp3;
  wire pda;
  wire [159:0] lit;
  int bad_count = 0;
  int n_compared = 0;
  int cyc_n = 0;
  logic [3:0] mem [40]; // expected display nibbles
  logic [31:0] rdv; // last read data
  logic [31:0] rdv_s; // last read data, smaller package
  logic [31:0] ctl;
  logic [31:0] rows [6][3] = '{'{32'h0, 32'hffff_ffa5, 32'h5}, '{32'h9c, 32'h1e, 32'he},
    '{32'ha0, 32'hf, 32'h0}, '{32'h200, 32'hffff_ffff, 32'h0}, '{32'h8c, 32'h17, 32'h7},
    '{32'h90, 32'h3, 32'h3}}; // addr, write, read on the larger package

  always #12.5 ref_clk = ~ref_clk;

  lsb_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .frontplane_drive_outputs(fp), .backplane_drive_0(bp0),
    .backplane_drive_1(bp1), .backplane_drive_2(bp2), .backplane_drive_3(bp3),
    .panel_drive_active(pda));
  lsb_panel_model panel (.fp(fp), .bp({bp3, bp2, bp1, bp0}), .lit(lit));
  // smaller package build on the same bus, only its readback is compared here
  lsb_top #(.SEG_COUNT(36)) dut_small (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(hrdata_s),
    .frontplane_drive_outputs(), .backplane_drive_0(), .backplane_drive_1(),
    .backplane_drive_2(), .backplane_drive_3(), .panel_drive_active());

  // ************************************************************
  // tasks
  // ************************************************************
  task test_done();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task cmp(input string nm, input logic [79:0] e, input logic [79:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one single word transfer, entered just after a rising edge
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
    rdv_s = hrdata_s;
    cmp("response", 0, hresp);
  endtask

  // watch pins each cycle; selection and phase are read off the backplanes
  task scan(input int nsl, input logic bias, input logic on, input int dv);
    int sel, psel, run, nev, ns;
    logic ph, pph;
    logic [1:0] b [4];
    logic [79:0] ef;
    logic [39:0] er;
    psel = -1;
    run = 0;
    nev = 0;
    pph = 1'b0;
    repeat (3 * nsl * (dv + 1) + 2) begin
      @(negedge ref_clk);
      b = '{bp0, bp1, bp2, bp3};
      sel = -1;
      ns = 0;
      for (int k = 0; k < nsl; k++) if (b[k][0] == b[k][1]) begin
        sel = k;
        ns++;
      end
      ph = sel >= 0 && b[sel] == lsb_pkg::LVL_TOP;
      cmp("selected count", on || nsl == 1, ns);
      if (nsl > 1) for (int k = nsl; k < 4; k++) cmp("open backplane", 0, b[k]);
      for (int k = 0; k < nsl; k++) begin
        for (int i = 0; i < 40; i++) er[i] = on && k == sel && mem[i][k];
        cmp("lit pixels", er, lit[k*40 +: 40]);
      end
      if (sel >= 0) begin
        // middle rails only for deselect in third bias
        for (int i = 0; i < 40; i++)
          ef[2*i +: 2] = (on && mem[i][sel]) ? {2{!ph}} : (bias && nsl > 1) ? {ph, !ph} : {2{ph}};
        cmp("segments", ef, fp);
        for (int k = 0; k < nsl; k++) if (k != sel)
          cmp("idle backplane", bias ? {!ph, ph} : lsb_pkg::LVL_UP, b[k]);
        if (nsl == 1) cmp("twins", {4{bp0}}, {bp3, bp2, bp1, bp0});
        if (sel != psel || ph != pph) begin
          if (nev > 1) cmp("slot length", dv + 1, run);
          if (nev > 1 && nsl > 1) cmp("next slot", (psel + 1) % nsl, sel);
          if (nev > 1) cmp("frame flip", sel == 0, ph != pph);
          nev++;
          run = 0;
        end
        run++;
        psel = sel;
        pph = ph;
      end
    end
    if (on) cmp("boundaries", 1, nev > 3);
    @(posedge ref_clk);
  endtask

  // ************************************************************
  // sequence
  // ************************************************************
  always @(posedge ref_clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    cmp("ready in reset", 1, hreadyout);
    cmp("pins in reset", 0, fp);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    xfer(0, lsb_pkg::CTRL_ADDR, 0);
    cmp("control reset", lsb_pkg::CTRL_RESET, rdv);
    for (int r = 0; r < 4; r++) begin
      xfer(1, rows[r][0], rows[r][1]);
      xfer(0, rows[r][0], 0);
      cmp("read back", rows[r][2], rdv);
      cmp("small read back", (rows[r][0] < 32'h90) ? rows[r][2] : 32'h0, rdv_s);
    end
    for (int i = 0; i < 40; i++) begin
      mem[i] = 4'((i * 7 + 3) % 16);
      xfer(1, 4 * i, {28'habcdef0, mem[i]});
    end
    // every slot count with both biases, divider 0 to 2
    for (int m = 0; m < 8; m++) begin
      ctl = {16'(m % 3), 8'h0, 8'h40 | 8'(m)};
      xfer(1, lsb_pkg::CTRL_ADDR, 0);
      xfer(1, lsb_pkg::CTRL_ADDR, ctl);
      repeat (4) @(posedge ref_clk);
      cmp("enable flag", 1, pda);
      scan(m % 4 + 1, m[2], 0, m % 3);
      xfer(1, lsb_pkg::CTRL_ADDR, ctl | 32'h80);
      repeat (4) @(posedge ref_clk);
      scan(m % 4 + 1, m[2], 1, m % 3);
      xfer(0, lsb_pkg::STAT_ADDR, 0);
      cmp("run flag", 1, rdv[lsb_pkg::STAT_RUN_BIT]);
      cmp("slot in range", 1, rdv[1:0] < m % 4 + 1);
      xfer(0, lsb_pkg::CTRL_ADDR, 0);
      cmp("control read", ctl | 32'h80, rdv);
    end
    // display on without output enable stays dark
    xfer(1, lsb_pkg::CTRL_ADDR, 32'h80);
    repeat (4) @(posedge ref_clk);
    cmp("refused segments", 0, fp);
    cmp("refused backplanes", 0, {pda, bp3, bp2, bp1, bp0});
    // reset in mid-run
    xfer(1, lsb_pkg::CTRL_ADDR, 32'h0001_00c3);
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    cmp("pins after reset", 0, fp);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    xfer(0, lsb_pkg::CTRL_ADDR, 0);
    cmp("control after reset", lsb_pkg::CTRL_RESET, rdv);
    xfer(0, lsb_pkg::STAT_ADDR, 0);
    cmp("status after reset", 0, rdv);
    test_done();
  end
endmodule

bind lsb_top lsb_monitor #(.SEG_COUNT(SEG_COUNT)) mon (.ref_clk(ref_clk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .frontplane_drive_outputs(frontplane_drive_outputs),
  .backplane_drive_0(backplane_drive_0), .backplane_drive_1(backplane_drive_1),
  .backplane_drive_2(backplane_drive_2), .backplane_drive_3(backplane_drive_3),
  .panel_drive_active(panel_drive_active));
